// file: rtl/nc_axis_mode_status_flags.sv
`timescale 1ns/1ps
`default_nettype none

module nc_axis_mode_status_flags (
  input  wire  logic                                   sys_clk,
  input  wire  logic                                   rst_n,
  input  wire  logic                                   clk_en,
  // apb slave
  input  wire  logic                                   psel,
  input  wire  logic                                   penable,
  input  wire  logic                                   pwrite,
  input  wire  logic [7:0]                             paddr,
  input  wire  logic [31:0]                            pwdata,
  output logic                                         pready,
  output logic [31:0]                                  prdata,
  output logic                                         pslverr,
  // axis motion events
  input  wire  logic [nc_status_pkg::NUM_AXES-1:0]     axis_at_ref,
  input  wire  nc_status_pkg::ref_point_t              ref_point_sel,
  input  wire  logic                                   return_cmd_active,
  input  wire  logic                                   auto_operation,
  input  wire  logic [nc_status_pkg::NUM_AXES-1:0]     axis_moved_away,
  input  wire  logic                                   emergency_stop,
  input  wire  logic                                   servo_alarm,
  input  wire  logic [nc_status_pkg::NUM_AXES*nc_status_pkg::POS_W-1:0] axis_offset,
  // program search
  input  wire  logic                                   search_start,
  input  wire  logic                                   search_number_valid,
  input  wire  logic                                   nc_reset,
  input  wire  logic                                   auto_start_req,
  output logic                                         auto_start_grant,
  // spindle
  input  wire  logic                                   mid_coil_request,
  input  wire  logic                                   low_coil_request,
  input  wire  logic                                   spindle_fwd_index_cmd,
  input  wire  logic                                   spindle_rev_index_cmd,
  input  wire  logic                                   spindle_orient_cmd,
  input  wire  logic                                   index_done,
  output logic [nc_status_pkg::POS_W-1:0]              orient_target,
  // mode selection
  input  wire  nc_status_pkg::mode_t                   mode_request,
  input  wire  logic                                   all_axes_smoothing_zero,
  // status bits to the sequence program
  output logic [nc_status_pkg::NUM_AXES-1:0]           second_ref_reached,
  output logic [nc_status_pkg::NUM_AXES-1:0]           third_ref_reached,
  output logic [nc_status_pkg::NUM_AXES-1:0]           fourth_ref_reached,
  output logic [nc_status_pkg::NUM_AXES-1:0]           near_home_zone,
  output logic                                         program_search_error,
  output logic                                         mid_coil_active_flag,
  output logic                                         low_coil_active_flag,
  output logic                                         index_complete,
  output logic                                         continuous_manual_feed_mode_active,
  output logic                                         handwheel_feed_mode_active,
  output logic                                         incremental_feed_mode_active,
  output logic                                         random_feed_mode_active,
  output logic                                         homing_return_mode_active,
  output logic                                         auto_initial_set_mode_active,
  output logic                                         stored_program_mode_active,
  output logic                                         paper_tape_mode_active,
  output logic                                         keyboard_entry_mode_active
);
  import nc_status_pkg::*;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // signed window test around the first reference point
  function automatic logic in_zone(input logic [POS_W-1:0] off, input logic [POS_W-1:0] plus,
                                   input logic [POS_W-1:0] minus);
    logic signed [POS_W:0] s;
    s = $signed({off[POS_W-1], off});
    in_zone = (s <= $signed({1'b0, plus})) && (s >= -$signed({1'b0, minus}));
  endfunction : in_zone

  // one-hot indicator pattern for a mode code
  function automatic logic [NUM_MODES-1:0] mode_bits(input mode_t m);
    mode_bits = '0;
    if (m != MODE_NONE) begin
      mode_bits[4'(m - 4'd1)] = 1'b1;
    end
  endfunction : mode_bits

  // ****************************************************************
  // registers
  // ****************************************************************
  logic                          abs_detect_reg;
  logic [POS_W-1:0]              near_plus_reg;
  logic [POS_W-1:0]              near_minus_reg;
  logic [POS_W-1:0]              grid_width_reg;
  logic [POS_W-1:0]              orient_shift_reg;
  logic [POS_W-1:0]              multi_point_reg;
  logic [NUM_AXES-1:0]           ref2_reg;
  logic [NUM_AXES-1:0]           ref3_reg;
  logic [NUM_AXES-1:0]           ref4_reg;
  logic [NUM_AXES-1:0]           near_reg;
  logic                          search_err_reg;
  logic                          mcoil_reg;
  logic                          lcoil_reg;
  logic                          index_cplt_reg;
  logic                          index_cmd_reg;
  logic                          grant_reg;
  logic [POS_W-1:0]              orient_target_reg;
  mode_t                         mode_reg;
  logic [NUM_MODES-1:0]          mode_bits_reg;
  logic                          pready_reg;
  logic                          pslverr_reg;
  logic [31:0]                   prdata_reg;
  logic [31:0]                   rd_next;
  logic                          rd_hit;
  logic                          access;
  logic                          fault_stop;
  logic                          ref_ok;
  logic                          index_start;

  assign access      = psel & penable & ~pready_reg;
  assign fault_stop  = emergency_stop | servo_alarm;
  assign ref_ok      = auto_operation & return_cmd_active;
  assign index_start = (spindle_fwd_index_cmd | spindle_rev_index_cmd) & ~index_cmd_reg;

  // ****************************************************************
  // apb slave: one wait state, registered answer
  // ****************************************************************
  // read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    rd_next = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      ADDR_CTRL:        rd_next[CTRL_ABS_BIT] = abs_detect_reg;
      ADDR_NEAR_PLUS:   rd_next[POS_W-1:0] = near_plus_reg;
      ADDR_NEAR_MINUS:  rd_next[POS_W-1:0] = near_minus_reg;
      ADDR_GRID_WIDTH:  rd_next[POS_W-1:0] = grid_width_reg;
      ADDR_ORIENT_SHFT: rd_next[POS_W-1:0] = orient_shift_reg;
      ADDR_MULTI_POINT: rd_next[POS_W-1:0] = multi_point_reg;
      ADDR_STATUS: begin
        rd_next[ST_NEAR_LSB +: NUM_AXES]   = near_reg;
        rd_next[ST_SSE_BIT]                = search_err_reg;
        rd_next[ST_MCOIL_BIT]              = mcoil_reg;
        rd_next[ST_LCOIL_BIT]              = lcoil_reg;
        rd_next[ST_INDEX_BIT]              = index_cplt_reg;
        rd_next[ST_MODE_LSB +: NUM_MODES]  = mode_bits_reg;
      end
      ADDR_REF_FLAGS:   rd_next[3*NUM_AXES-1:0] = {ref4_reg, ref3_reg, ref2_reg};
      default:          rd_hit = 1'b0;
    endcase
  end

  // bus handshake and read data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_reg  <= access;
      pslverr_reg <= access & ~rd_hit;
      prdata_reg  <= (access & ~pwrite) ? rd_next : 32'h0000_0000;
    end
  end

  // software configuration; writes land at the completing edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abs_detect_reg   <= 1'b0;
      near_plus_reg    <= RST_WIDTH;
      near_minus_reg   <= RST_WIDTH;
      grid_width_reg   <= RST_GRID_WIDTH;
      orient_shift_reg <= RST_WIDTH;
      multi_point_reg  <= RST_WIDTH;
    end else if (clk_en && psel && penable && pready_reg && pwrite) begin
      case (paddr)
        ADDR_CTRL:        abs_detect_reg   <= pwdata[CTRL_ABS_BIT];
        ADDR_NEAR_PLUS:   near_plus_reg    <= pwdata[POS_W-1:0];
        ADDR_NEAR_MINUS:  near_minus_reg   <= pwdata[POS_W-1:0];
        ADDR_GRID_WIDTH:  grid_width_reg   <= pwdata[POS_W-1:0];
        ADDR_ORIENT_SHFT: orient_shift_reg <= pwdata[POS_W-1:0];
        ADDR_MULTI_POINT: multi_point_reg  <= pwdata[POS_W-1:0];
        default:          ;
      endcase
    end
  end

  // ****************************************************************
  // reference point reached flags
  // ****************************************************************
  // fault stop dominates; otherwise an arrival beats a move-away edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref2_reg <= '0;
      ref3_reg <= '0;
      ref4_reg <= '0;
    end else if (clk_en) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (fault_stop) begin
          ref2_reg[a] <= 1'b0;
          ref3_reg[a] <= 1'b0;
          ref4_reg[a] <= 1'b0;
        end else if (axis_at_ref[a] && ref_ok) begin
          ref2_reg[a] <= ref2_reg[a] | (ref_point_sel == REF_SECOND);
          ref3_reg[a] <= ref3_reg[a] | (ref_point_sel == REF_THIRD);
          ref4_reg[a] <= ref4_reg[a] | (ref_point_sel == REF_FOURTH);
        end else if (axis_moved_away[a]) begin
          ref2_reg[a] <= 1'b0;
          ref3_reg[a] <= 1'b0;
          ref4_reg[a] <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // near home zone
  // ****************************************************************
  // zero widths fall back to the grid width on both sides
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      near_reg <= '0;
    end else if (clk_en) begin
      for (int a = 0; a < NUM_AXES; a++) begin
        if (!abs_detect_reg) begin
          near_reg[a] <= 1'b0;
        end else if (near_plus_reg == RST_WIDTH && near_minus_reg == RST_WIDTH) begin
          near_reg[a] <= in_zone(axis_offset[a*POS_W +: POS_W], grid_width_reg, grid_width_reg);
        end else begin
          near_reg[a] <= in_zone(axis_offset[a*POS_W +: POS_W], near_plus_reg, near_minus_reg);
        end
      end
    end
  end

  // ****************************************************************
  // program search error and start gate
  // ****************************************************************
  // a failed search in the reset cycle still raises the flag
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      search_err_reg <= 1'b0;
      grant_reg      <= 1'b0;
    end else if (clk_en) begin
      if (search_start) begin
        search_err_reg <= ~search_number_valid;
      end else if (nc_reset) begin
        search_err_reg <= 1'b0;
      end
      grant_reg <= auto_start_req & ~search_err_reg & ~(search_start & ~search_number_valid);
    end
  end

  // ****************************************************************
  // spindle coil, index and orientation
  // ****************************************************************
  // coil flags mirror the requests; both set gives both flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mcoil_reg <= 1'b0;
      lcoil_reg <= 1'b0;
    end else if (clk_en) begin
      mcoil_reg <= mid_coil_request;
      lcoil_reg <= low_coil_request;
    end
  end

  // completion wins over a start edge in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_cplt_reg <= 1'b1;
      index_cmd_reg  <= 1'b0;
    end else if (clk_en) begin
      index_cmd_reg <= spindle_fwd_index_cmd | spindle_rev_index_cmd;
      if (index_done) begin
        index_cplt_reg <= 1'b1;
      end else if (index_start) begin
        index_cplt_reg <= 1'b0;
      end
    end
  end

  // target latched at the command, so angle data must be settled first
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      orient_target_reg <= '0;
    end else if (clk_en && (spindle_orient_cmd || index_start)) begin
      orient_target_reg <= POS_W'(orient_shift_reg + multi_point_reg);
    end
  end

  // ****************************************************************
  // operating mode indicators
  // ****************************************************************
  // held until all axes show zero smoothing, then switched in one edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg      <= MODE_NONE;
      mode_bits_reg <= '0;
    end else if (clk_en && all_axes_smoothing_zero && mode_request != mode_reg) begin
      mode_reg      <= mode_request;
      mode_bits_reg <= mode_bits(mode_request);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pready                             = pready_reg;
  assign pslverr                            = pslverr_reg;
  assign prdata                             = prdata_reg;
  assign second_ref_reached                 = ref2_reg;
  assign third_ref_reached                  = ref3_reg;
  assign fourth_ref_reached                 = ref4_reg;
  assign near_home_zone                     = near_reg;
  assign program_search_error               = search_err_reg;
  assign auto_start_grant                   = grant_reg;
  assign mid_coil_active_flag               = mcoil_reg;
  assign low_coil_active_flag               = lcoil_reg;
  assign index_complete                     = index_cplt_reg;
  assign orient_target                      = orient_target_reg;
  assign continuous_manual_feed_mode_active = mode_bits_reg[0];
  assign handwheel_feed_mode_active         = mode_bits_reg[1];
  assign incremental_feed_mode_active       = mode_bits_reg[2];
  assign random_feed_mode_active            = mode_bits_reg[3];
  assign homing_return_mode_active          = mode_bits_reg[4];
  assign auto_initial_set_mode_active       = mode_bits_reg[5];
  assign stored_program_mode_active         = mode_bits_reg[6];
  assign paper_tape_mode_active             = mode_bits_reg[7];
  assign keyboard_entry_mode_active         = mode_bits_reg[8];

  // ****************************************************************
  // checks
  // ****************************************************************
  ref_set_auto_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && axis_at_ref[0] && ref_ok && ref_point_sel == REF_SECOND && !fault_stop
    |=> second_ref_reached[0]) else $error("second ref flag not set");
  ref_no_manual_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && !ref_ok && !second_ref_reached[1] |=> !second_ref_reached[1])
    else $error("ref flag set outside auto return");
  ref_move_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && axis_moved_away[2] && !axis_at_ref[2] |=> !third_ref_reached[2])
    else $error("ref flag kept after move away");
  ref_fault_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && fault_stop |=> (second_ref_reached | third_ref_reached | fourth_ref_reached) == '0)
    else $error("ref flags kept after fault stop");
  search_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && search_start && !search_number_valid |=> program_search_error && !auto_start_grant)
    else $error("illegal search did not raise error");
  start_block_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && program_search_error |=> !auto_start_grant)
    else $error("auto start granted with search error");
  coil_follow_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en |=> mid_coil_active_flag == $past(mid_coil_request) && low_coil_active_flag == $past(low_coil_request))
    else $error("coil flags do not follow requests");
  index_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && index_start && !index_done |=> !index_complete)
    else $error("index complete not cleared at start");
  near_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !abs_detect_reg ##1 !abs_detect_reg && $past(clk_en) |-> near_home_zone == '0)
    else $error("near zone without absolute detection");
  mode_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !all_axes_smoothing_zero |=> $stable(mode_bits_reg))
    else $error("mode changed before smoothing zero");
  mode_onehot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $onehot0(mode_bits_reg)) else $error("more than one mode bit");

endmodule : nc_axis_mode_status_flags

`default_nettype wire

// file: rtl/nc_status_pkg.sv
`default_nettype none
package nc_status_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_AXES  = 4;
  localparam int POS_W     = 16;
  localparam int NUM_MODES = 9;

  // ****************************************************************
  // register map (byte addresses) and reset values
  // ****************************************************************
  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_NEAR_PLUS   = 8'h04;
  localparam logic [7:0]  ADDR_NEAR_MINUS  = 8'h08;
  localparam logic [7:0]  ADDR_GRID_WIDTH  = 8'h0c;
  localparam logic [7:0]  ADDR_ORIENT_SHFT = 8'h10;
  localparam logic [7:0]  ADDR_MULTI_POINT = 8'h14;
  localparam logic [7:0]  ADDR_STATUS      = 8'h18;
  localparam logic [7:0]  ADDR_REF_FLAGS   = 8'h1c;

  localparam int          CTRL_ABS_BIT     = 0;
  localparam logic [15:0] RST_WIDTH        = 16'h0000;
  localparam logic [15:0] RST_GRID_WIDTH   = 16'h0100;

  // status word field positions
  localparam int ST_NEAR_LSB   = 0;
  localparam int ST_SSE_BIT    = 4;
  localparam int ST_MCOIL_BIT  = 5;
  localparam int ST_LCOIL_BIT  = 6;
  localparam int ST_INDEX_BIT  = 7;
  localparam int ST_MODE_LSB   = 8;

  // which reference point a return command is aimed at
  typedef enum logic [1:0] {
    REF_NONE   = 2'b00,
    REF_SECOND = 2'b01,
    REF_THIRD  = 2'b10,
    REF_FOURTH = 2'b11
  } ref_point_t;

  // operating modes; bit index of the one-hot indicator is code minus one
  typedef enum logic [3:0] {
    MODE_NONE     = 4'b0000,
    MODE_JOG      = 4'b0001,
    MODE_HANDLE   = 4'b0010,
    MODE_INCR     = 4'b0011,
    MODE_RANDOM   = 4'b0100,
    MODE_HOMING   = 4'b0101,
    MODE_AUTOSET  = 4'b0110,
    MODE_MEMORY   = 4'b0111,
    MODE_TAPE     = 4'b1000,
    MODE_KEYBOARD = 4'b1001
  } mode_t;

endpackage : nc_status_pkg
`default_nettype wire

// file: test/index_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// sequence program side of spindle indexing
// ****************
module index_ctrl_model #(
  parameter int HOLD_CYC = 4000000 // 100 ms at 40 MHz
) (
  input  wire logic sys_clk,
  input  wire logic go,
  input  wire logic dir,
  input  wire logic angle_loaded,
  output logic      spindle_fwd_index_cmd,
  output logic      spindle_rev_index_cmd,
  output logic      check_ok
);
  int cnt = 0;
  // no command before the angle is in; the flag is trusted only after the hold-off
  always_ff @(posedge sys_clk) begin
    spindle_fwd_index_cmd <= go && angle_loaded && !dir;
    spindle_rev_index_cmd <= go && angle_loaded && dir;
    cnt <= go ? cnt + 1 : 0;
    check_ok <= go && cnt >= HOLD_CYC;
  end
endmodule : index_ctrl_model
`default_nettype wire

// file: test/nc_axis_mode_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nc_axis_mode_status_flags_tb;
  import nc_status_pkg::*;
  // ****************
  // bench state
  // ****************
  logic sys_clk = 0, rst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic return_cmd_active = 0, auto_operation = 0, emergency_stop = 0, servo_alarm = 0;
  logic search_start = 0, search_number_valid = 0, nc_reset = 0, auto_start_req = 0, auto_start_grant;
  logic mid_coil_request = 0, low_coil_request = 0, spindle_orient_cmd = 0, index_done = 0;
  logic all_axes_smoothing_zero = 0, go = 0, dir = 0, angle_loaded = 0, check_ok, index_complete;
  logic spindle_fwd_index_cmd, spindle_rev_index_cmd, program_search_error;
  logic mid_coil_active_flag, low_coil_active_flag;
  logic [3:0] axis_at_ref = 0, axis_moved_away = 0, near_home_zone, a;
  logic [3:0] second_ref_reached, third_ref_reached, fourth_ref_reached;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r, seed = 32'h59;
  logic [63:0] axis_offset = 0;
  logic [15:0] orient_target;
  logic [8:0] md;
  ref_point_t ref_point_sel = REF_NONE;
  mode_t mode_request = MODE_NONE;
  int n_mismatch = 0, checks = 0, pw, mw;
  wire logic [11:0] rf = {fourth_ref_reached, third_ref_reached, second_ref_reached};
  nc_axis_mode_status_flags DUT (.*,
    .continuous_manual_feed_mode_active(md[0]), .handwheel_feed_mode_active(md[1]),
    .incremental_feed_mode_active(md[2]), .random_feed_mode_active(md[3]),
    .homing_return_mode_active(md[4]), .auto_initial_set_mode_active(md[5]),
    .stored_program_mode_active(md[6]), .paper_tape_mode_active(md[7]), .keyboard_entry_mode_active(md[8]));
  index_ctrl_model #(.HOLD_CYC(100)) partner (.*);
  initial forever #12.5 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // zero widths fall back to the grid width on both sides
  function automatic logic [3:0] near_exp(int p, int m);
    logic [3:0] f;
    if (p == 0 && m == 0) begin
      p = RST_GRID_WIDTH;
      m = RST_GRID_WIDTH;
    end
    for (int i = 0; i < 4; i++) f[i] = $signed(axis_offset[16*i+:16]) >= -m && $signed(axis_offset[16*i+:16]) <= p;
    return f;
  endfunction : near_exp
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic chk(string nm, logic [31:0] x, logic [31:0] got);
    checks++;
    if (got !== x) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, x, got);
    end
  endtask : chk
  // request held until pready is seen at a rising edge
  task automatic apb(logic w, logic [7:0] ad, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    cyc(1);
    penable <= 1;
    // no assumed latency; only the watchdog ends a stuck wait
    do begin
      cyc(1);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    // one idle edge so a following call never reassigns psel in this step
    cyc(1);
  endtask : apb
  task automatic summarize();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  // watchdog, far beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    cyc(20);
    rst_n <= 1;
    cyc(1);
    chk("index_complete", 1, index_complete);
    apb(0, ADDR_GRID_WIDTH, 0);
    chk("grid_width", RST_GRID_WIDTH, r);
    apb(0, 8'h40, 0);
    chk("pslverr", 1, e);
    for (int p = 1; p < 4; p++) begin
      a = 4'h1 << (rnd() % 4);
      ref_point_sel <= ref_point_t'(p);
      return_cmd_active <= 1;
      axis_at_ref <= a;
      cyc(2);
      chk("ref_manual", 0, rf);
      auto_operation <= 1;
      cyc(2);
      chk("ref_set", 12'(a) << 4*(p-1), rf);
      axis_at_ref <= 0;
      axis_moved_away <= a;
      cyc(2);
      chk("ref_away", 0, rf);
      axis_moved_away <= 0;
      axis_at_ref <= a;
      cyc(2);
      axis_at_ref <= 0;
      emergency_stop <= p[0];
      servo_alarm <= !p[0];
      cyc(2);
      chk("ref_stop", 0, rf);
      emergency_stop <= 0;
      servo_alarm <= 0;
      auto_operation <= 0;
    end
    auto_start_req <= 1;
    for (int v = 0; v < 3; v++) begin
      search_start <= 1;
      search_number_valid <= v == 1;
      cyc(1);
      search_start <= 0;
      nc_reset <= v == 2;
      cyc(3);
      chk("search_err", v == 0, program_search_error);
      chk("grant", v != 0, auto_start_grant);
    end
    nc_reset <= 0;
    for (int c = 0; c < 4; c++) begin
      {low_coil_request, mid_coil_request} <= c[1:0];
      cyc(2);
      chk("coil", c, {low_coil_active_flag, mid_coil_active_flag});
    end
    // clock enable low must freeze the flags although the request moves
    clk_en <= 0;
    mid_coil_request <= 0;
    cyc(2);
    chk("coil_freeze", 3, {low_coil_active_flag, mid_coil_active_flag});
    clk_en <= 1;
    cyc(2);
    chk("coil_resume", 2, {low_coil_active_flag, mid_coil_active_flag});
    pw = rnd() % 16384;
    mw = rnd() % 16384;
    apb(1, ADDR_ORIENT_SHFT, pw);
    apb(1, ADDR_MULTI_POINT, mw);
    angle_loaded <= 1;
    spindle_orient_cmd <= 1;
    cyc(2);
    chk("orient", pw + mw, orient_target);
    spindle_orient_cmd <= 0;
    for (int d = 0; d < 2; d++) begin
      dir <= d[0];
      go <= 1;
      for (int n = 0; n < 500 && check_ok !== 1'b1; n++) cyc(1);
      chk("index_run", 0, index_complete);
      go <= 0;
      index_done <= 1;
      cyc(1);
      index_done <= 0;
      cyc(2);
      chk("index_done", 1, index_complete);
    end
    apb(1, ADDR_CTRL, 1);
    for (int k = 0; k < 5; k++) begin
      pw = k ? rnd() % 16 : 0;
      mw = k ? rnd() % 16 : 0;
      for (int i = 0; i < 4; i++) axis_offset[16*i+:16] <= 16'((int'(rnd() % 41) - 20) * (k ? 1 : 16));
      apb(1, ADDR_NEAR_PLUS, pw);
      apb(1, ADDR_NEAR_MINUS, mw);
      cyc(2);
      chk("near", near_exp(pw, mw), near_home_zone);
    end
    apb(1, ADDR_CTRL, 0);
    cyc(2);
    chk("near_off", 0, near_home_zone);
    for (int k = 1; k < 10; k++) begin
      all_axes_smoothing_zero <= 0;
      mode_request <= mode_t'(k);
      cyc(3);
      chk("mode_hold", k > 1 ? 9'h1 << (k - 2) : 9'h0, md);
      all_axes_smoothing_zero <= 1;
      cyc(2);
      chk("mode", 9'h1 << (k - 1), md);
    end
    summarize();
  end
endmodule : nc_axis_mode_status_flags_tb
`default_nettype wire
